// [logic/uhld_addr_gen.sv]
`timescale 1ns/1ns
`default_nettype none
module uhld_addr_gen
  import uhld_pkg::*;
(
  // Operands
  input wire uhld_op_t op,
  input wire logic [XLEN-1:0] base_val,
  input wire logic [XLEN-1:0] index_val,
  input wire logic [OFFSET_W-1:0] offset,
  // Results
  output logic [XLEN-1:0] effective_byte_address,
  output logic misaligned
);
  wire logic [XLEN-1:0] offset_sext = {{(XLEN-OFFSET_W){offset[OFFSET_W-1]}}, offset};
  wire logic use_index = (op == UHLD_OP_FPX);
  wire logic [XLEN-1:0] addend = use_index ? index_val : offset_sext;
  wire logic half_op = (op == UHLD_OP_HALF_S) || (op == UHLD_OP_HALF_U);

  assign effective_byte_address = base_val + addend;
  assign misaligned = (use_index && (effective_byte_address[LANE_W-1:0] != LANE_ZERO))
                   || (half_op && effective_byte_address[0]);
endmodule : uhld_addr_gen
`default_nettype wire

// [logic/uhld_datapath.sv]
`timescale 1ns/1ns
`default_nettype none
module uhld_datapath
  import uhld_pkg::*;
#(
  parameter int PADDR_W = 40
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Issue
  input wire logic issue_valid,
  input wire uhld_op_t op,
  input wire logic [XLEN-1:0] base_val,
  input wire logic [XLEN-1:0] index_val,
  input wire logic [OFFSET_W-1:0] offset,
  input wire logic [XLEN-1:0] old_target,
  input wire logic reserved_instr_in,
  input wire logic cop_unusable_in,
  input wire uhld_order_t order_cfg,
  // Address to memory path
  output logic req_valid_ff,
  output logic [XLEN-1:0] vaddr_ff,
  input wire logic [PADDR_W-1:0] paddr_in,
  output logic [PADDR_W-1:0] paddr_adj_ff,
  // Memory answer
  input wire logic mem_valid,
  input wire logic [XLEN-1:0] mem_dword,
  input wire logic tlb_refill_in,
  input wire logic tlb_invalid_in,
  input wire logic bus_error_in,
  input wire logic watch_in,
  // Result
  output logic done_ff,
  output logic [XLEN-1:0] result_ff,
  output uhld_exc_t exc_ff
);
  // ==========================================================
  // State
  typedef enum logic [1:0] {
    UHLD_IDLE = 2'h0,
    UHLD_WAIT = 2'h1
  } uhld_state_t;

  uhld_state_t state_ff, nxt_state;
  uhld_op_t op_ff;
  logic [XLEN-1:0] old_ff;
  uhld_order_t ord_ff;
  logic [XLEN-1:0] ea;
  logic misaligned;
  logic [XLEN-1:0] merged;

  // ==========================================================
  // Address generation
  uhld_addr_gen u_addr (
    .op(op),
    .base_val(base_val),
    .index_val(index_val),
    .offset(offset),
    .effective_byte_address(ea),
    .misaligned(misaligned)
  );

  // ==========================================================
  // Lane select, flags applied combinationally
  wire logic half_op_q = (op_ff == UHLD_OP_HALF_S) || (op_ff == UHLD_OP_HALF_U);
  wire logic part_op_q = (op_ff == UHLD_OP_LEFT) || (op_ff == UHLD_OP_RIGHT);
  wire logic big = ord_ff.core_byte_order_big;
  wire logic [LANE_W-1:0] order_mask = half_op_q ? {big, big, 1'b0} : {3{big}};
  wire logic [LANE_W-1:0] lane = vaddr_ff[LANE_W-1:0] ^ order_mask;

  uhld_merge u_merge (
    .op(op_ff),
    .lane(lane),
    .mem_dword(mem_dword),
    .old_target(old_ff),
    .result(merged)
  );

  // Physical low bits: reverse flips, part loads may clear by memory order
  wire logic rev = order_cfg.user_order_reversed;
  wire logic half_now = (op == UHLD_OP_HALF_S) || (op == UHLD_OP_HALF_U);
  wire logic [LANE_W-1:0] rev_mask = half_now ? {rev, rev, 1'b0} : {3{rev}};
  wire logic [LANE_W-1:0] p_low_x = paddr_in[LANE_W-1:0] ^ rev_mask;
  wire logic clr_low = ((op == UHLD_OP_LEFT) && !order_cfg.memory_order_big)
                    || ((op == UHLD_OP_RIGHT) && order_cfg.memory_order_big);
  wire logic [LANE_W-1:0] p_low = clr_low ? LANE_ZERO : p_low_x;

  // ==========================================================
  // Exception assembly
  wire logic issue = issue_valid && (state_ff == UHLD_IDLE) && (op != UHLD_OP_NONE);
  wire logic fpx_now = (op == UHLD_OP_FPX);
  wire logic part_now = (op == UHLD_OP_LEFT) || (op == UHLD_OP_RIGHT);
  // Part loads and FP load take reserved-instruction; signed half never
  wire logic ri_ok = part_now || fpx_now;
  wire logic early_fault = misaligned
                        || (ri_ok && reserved_instr_in)
                        || (fpx_now && cop_unusable_in);
  // Indexed FP load has no bus error in its list
  wire logic bus_ok = part_op_q || half_op_q;

  uhld_exc_t early_exc;
  assign early_exc = '{
    tlb_refill: 1'b0,
    tlb_invalid: 1'b0,
    bus_error: 1'b0,
    addr_error: misaligned,
    reserved_instr: ri_ok && reserved_instr_in,
    cop_unusable: fpx_now && cop_unusable_in,
    watch: 1'b0
  };
  uhld_exc_t late_exc;
  assign late_exc = '{
    tlb_refill: tlb_refill_in,
    tlb_invalid: tlb_invalid_in,
    bus_error: bus_ok && bus_error_in,
    addr_error: 1'b0,
    reserved_instr: 1'b0,
    cop_unusable: 1'b0,
    watch: watch_in
  };
  wire logic late_fault = tlb_refill_in || tlb_invalid_in || (bus_ok && bus_error_in) || watch_in;

  // ==========================================================
  // Sequencing
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      UHLD_IDLE: if (issue && !early_fault) nxt_state = UHLD_WAIT;
      UHLD_WAIT: if (mem_valid) nxt_state = UHLD_IDLE;
      default: nxt_state = UHLD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_ff <= UHLD_IDLE;
      op_ff <= UHLD_OP_NONE;
      old_ff <= '0;
      ord_ff <= '0;
      req_valid_ff <= 1'b0;
      vaddr_ff <= '0;
      paddr_adj_ff <= '0;
      done_ff <= 1'b0;
      result_ff <= '0;
      exc_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      req_valid_ff <= issue && !early_fault;
      done_ff <= 1'b0;
      if (issue)
      begin
        op_ff <= op;
        old_ff <= old_target;
        ord_ff <= order_cfg;
        vaddr_ff <= ea;
        paddr_adj_ff <= {paddr_in[PADDR_W-1:LANE_W], p_low};
      end
      if (issue && early_fault)
      begin
        done_ff <= 1'b1;
        exc_ff <= early_exc;
        result_ff <= old_target;
      end
      else if ((state_ff == UHLD_WAIT) && mem_valid)
      begin
        done_ff <= 1'b1;
        exc_ff <= late_exc;
        result_ff <= late_fault ? old_ff : merged;
      end
    end
  end

  // ==========================================================
  // Checks
  sequence issue_bad_s;
    issue && misaligned;
  endsequence

  no_req_misalign_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    issue_bad_s |=> !req_valid_ff && done_ff && exc_ff.addr_error)
    else $error("misaligned load reached memory");
  half_odd_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issue && half_now && ea[0]) |=> exc_ff.addr_error)
    else $error("odd half address not flagged");
  fpx_align_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issue && fpx_now && ea[2:0] == 3'h0 && !early_fault) |=> req_valid_ff && vaddr_ff[2:0] == 3'h0)
    else $error("aligned fp load not issued");
  ea_sum_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (issue && !fpx_now) |=> vaddr_ff == $past(base_val) + {{48{$past(offset[15])}}, $past(offset)})
    else $error("effective address wrong");
  half_signed_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_ff == UHLD_WAIT && mem_valid && op_ff == UHLD_OP_HALF_S && !late_fault)
    |=> result_ff[63:16] == {48{result_ff[15]}})
    else $error("signed half not extended");
  half_unsigned_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_ff == UHLD_WAIT && mem_valid && op_ff == UHLD_OP_HALF_U && !late_fault)
    |=> result_ff[63:16] == 48'h0)
    else $error("unsigned half not zero extended");
  right_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_ff == UHLD_WAIT && mem_valid && op_ff == UHLD_OP_RIGHT && !late_fault && lane == 3'h7)
    |=> result_ff[63:8] == $past(old_ff[63:8]))
    else $error("right part overwrote kept bytes");
  left_full_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_ff == UHLD_WAIT && mem_valid && op_ff == UHLD_OP_LEFT && !late_fault && lane == 3'h7)
    |=> result_ff == $past(mem_dword))
    else $error("left part full lane wrong");
  half_no_ri_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (done_ff && half_op_q) |-> !exc_ff.reserved_instr)
    else $error("half load raised reserved instruction");
endmodule : uhld_datapath
`default_nettype wire

// [logic/uhld_merge.sv]
`timescale 1ns/1ns
`default_nettype none
module uhld_merge
  import uhld_pkg::*;
(
  // Selection
  input wire uhld_op_t op,
  input wire logic [LANE_W-1:0] lane,
  // Data
  input wire logic [XLEN-1:0] mem_dword,
  input wire logic [XLEN-1:0] old_target,
  output logic [XLEN-1:0] result
);
  // Byte-granular keep masks for the two part loads
  wire logic [5:0] sh_left = {(3'h7 - lane), 3'h0};
  wire logic [5:0] sh_right = {lane, 3'h0};
  wire logic [XLEN-1:0] left_data = mem_dword << sh_left;
  wire logic [XLEN-1:0] left_keep = ~({XLEN{1'b1}} << sh_left);
  wire logic [XLEN-1:0] right_data = mem_dword >> sh_right;
  wire logic [XLEN-1:0] right_keep = ~({XLEN{1'b1}} >> sh_right);
  wire logic [XLEN-1:0] half_raw = mem_dword >> sh_right;
  wire logic [HALF_W-1:0] half = half_raw[HALF_W-1:0];

  always_comb
  begin
    case (op)
      UHLD_OP_LEFT: result = left_data | (old_target & left_keep);
      UHLD_OP_RIGHT: result = right_data | (old_target & right_keep);
      UHLD_OP_FPX: result = mem_dword;
      UHLD_OP_HALF_S: result = {{(XLEN-HALF_W){half[HALF_W-1]}}, half};
      UHLD_OP_HALF_U: result = {{(XLEN-HALF_W){1'b0}}, half};
      default: result = old_target;
    endcase
  end
endmodule : uhld_merge
`default_nettype wire

// [logic/uhld_pkg.sv]
package uhld_pkg;
  localparam int XLEN = 64;
  localparam int OFFSET_W = 16;
  localparam int LANE_W = 3;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [LANE_W-1:0] LANE_ZERO = 3'h0;

  typedef enum logic [2:0] {
    UHLD_OP_NONE = 3'h0,
    UHLD_OP_LEFT = 3'h1,
    UHLD_OP_RIGHT = 3'h3,
    UHLD_OP_FPX = 3'h2,
    UHLD_OP_HALF_S = 3'h6,
    UHLD_OP_HALF_U = 3'h7
  } uhld_op_t;

  // Exception flags raised by a load
  typedef struct packed {
    logic tlb_refill;
    logic tlb_invalid;
    logic bus_error;
    logic addr_error;
    logic reserved_instr;
    logic cop_unusable;
    logic watch;
  } uhld_exc_t;

  // Byte-order configuration
  typedef struct packed {
    logic core_byte_order_big;
    logic user_order_reversed;
    logic memory_order_big;
  } uhld_order_t;
endpackage : uhld_pkg

// [verification/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_top
  import uhld_pkg::*;
;
  // ==========================================
  // Stimulus and wiring
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic issue_valid = 1'b0;
  uhld_op_t op = UHLD_OP_NONE;
  logic [XLEN-1:0] base_val = '0, index_val = '0, old_target = '0, m_data = '0;
  logic [OFFSET_W-1:0] offset = '0;
  logic reserved_instr_in = 1'b0, cop_unusable_in = 1'b0;
  uhld_order_t order_cfg = '0;
  logic [39:0] paddr_in = '0, paddr_adj_ff;
  logic [3:0] m_flt = '0, flt;
  logic [1:0] m_dly = '0;
  logic req_valid_ff, mem_valid, done_ff;
  logic [XLEN-1:0] vaddr_ff, mem_dword, result_ff;
  uhld_exc_t exc_ff;
  int fails = 0, n_checks = 0;
  logic [63:0] seed = 64'h5C;
  uhld_op_t ops [5] = '{UHLD_OP_LEFT, UHLD_OP_RIGHT, UHLD_OP_FPX, UHLD_OP_HALF_S, UHLD_OP_HALF_U};

  always #25 ref_clk = ~ref_clk;

  uhld_datapath #(.PADDR_W(40)) dut (.ref_clk(ref_clk), .rstn(rstn), .issue_valid(issue_valid),
    .op(op), .base_val(base_val), .index_val(index_val), .offset(offset),
    .old_target(old_target), .reserved_instr_in(reserved_instr_in),
    .cop_unusable_in(cop_unusable_in), .order_cfg(order_cfg), .req_valid_ff(req_valid_ff),
    .vaddr_ff(vaddr_ff), .paddr_in(paddr_in), .paddr_adj_ff(paddr_adj_ff),
    .mem_valid(mem_valid), .mem_dword(mem_dword), .tlb_refill_in(flt[3]),
    .tlb_invalid_in(flt[2]), .bus_error_in(flt[1]), .watch_in(flt[0]), .done_ff(done_ff),
    .result_ff(result_ff), .exc_ff(exc_ff));

  uhld_mem_model mem (.ref_clk(ref_clk), .req(req_valid_ff), .data(m_data), .faults(m_flt),
    .delay(m_dly), .mem_valid(mem_valid), .mem_dword(mem_dword), .flt(flt));

  // ==========================================
  // Reference functions
  function logic [63:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction : rnd

  function logic [63:0] exp_res(uhld_op_t o, logic [2:0] va, logic big, logic [63:0] m,
                                logic [63:0] old);
    logic [2:0] lp;
    logic [2:0] lh;
    logic [15:0] h;
    lp = va ^ {3{big}};
    lh = va ^ {big, big, 1'b0};
    h = m[8*lh +: 16];
    case (o)
      UHLD_OP_LEFT: return (m << 8*(7-lp)) | (old & ((64'h1 << 8*(7-lp)) - 64'h1));
      UHLD_OP_RIGHT: return (m >> 8*lp) | (old & ~(~64'h0 >> 8*lp));
      UHLD_OP_HALF_S: return {{48{h[15]}}, h};
      UHLD_OP_HALF_U: return {48'h0, h};
      default: return m;
    endcase
  endfunction : exp_res

  // ==========================================
  // One load, issue to completion
  task do_load(input uhld_op_t o, input logic [63:0] b, x, old, md, input logic [15:0] f,
               input logic [2:0] cfg, input logic ri, cu, input logic [3:0] fl,
               input logic [1:0] dl);
    logic [63:0] va;
    logic [63:0] p;
    logic [39:0] pa;
    logic early;
    logic late;
    logic reqs;
    uhld_exc_t ex;
    int i;
    va = (o == UHLD_OP_FPX) ? b + x : b + {{48{f[15]}}, f};
    ex = '0;
    ex.addr_error = (o == UHLD_OP_FPX) ? |va[2:0] : o[2] & va[0];
    ex.reserved_instr = ri & ~o[2];
    ex.cop_unusable = cu;
    early = ex.addr_error | ex.reserved_instr | ex.cop_unusable;
    ex.tlb_refill = fl[3] & ~early;
    ex.tlb_invalid = fl[2] & ~early;
    ex.bus_error = fl[1] & ~early & (o != UHLD_OP_FPX);
    ex.watch = fl[0] & ~early;
    late = ex.tlb_refill | ex.tlb_invalid | ex.bus_error | ex.watch;
    p = rnd();
    paddr_in = p[39:0];
    pa = {p[39:3], p[2:0] ^ (o[2] ? {cfg[1], cfg[1], 1'b0} : {3{cfg[1]}})};
    if ((o == UHLD_OP_LEFT && !cfg[0]) || (o == UHLD_OP_RIGHT && cfg[0]))
      pa[2:0] = 3'h0;
    op = o;
    base_val = b;
    index_val = x;
    offset = f;
    old_target = old;
    order_cfg = cfg;
    reserved_instr_in = ri;
    cop_unusable_in = cu;
    m_data = md;
    m_flt = fl;
    m_dly = dl;
    issue_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    issue_valid = 1'b0;
    reqs = 1'b0;
    for (i = 0; i < 20; i++)
    begin
      if (req_valid_ff === 1'b1)
      begin
        reqs = 1'b1;
        `CHK(vaddr_ff, va)
        `CHK(paddr_adj_ff, pa)
      end
      if (done_ff === 1'b1)
        break;
      @(posedge ref_clk);
      #1;
    end
    `CHK(done_ff, 1'b1)
    `CHK(reqs, ~early)
    `CHK(exc_ff, ex)
    `CHK(result_ff, (early | late) ? old : exp_res(o, va[2:0], cfg[2], md, old))
  endtask : do_load

  task complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    logic [63:0] r;
    logic [63:0] b;
    logic [63:0] x;
    uhld_op_t o;
    repeat (10) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    // Unaligned doubleword at byte 2, big-endian core: right part then left part
    do_load(UHLD_OP_RIGHT, 64'h9, 64'h0, ~64'h0, 64'h0809_0A0B_0C0D_0E0F, 16'h0, 3'h4, 1'b0,
            1'b0, 4'h0, 2'h0);
    do_load(UHLD_OP_LEFT, 64'h2, 64'h0, 64'hFFFF_FFFF_FFFF_0809, 64'h0001_0203_0405_0607,
            16'h0, 3'h4, 1'b0, 1'b0, 4'h0, 2'h3);
    `CHK(result_ff, 64'h0203_0405_0607_0809)
    for (int n = 0; n < 300; n++)
    begin
      r = rnd();
      b = rnd();
      x = rnd();
      o = ops[r % 5];
      // Aligned indexed loads would be rare otherwise
      if (o == UHLD_OP_FPX && r[8])
        b[2:0] = 3'h0;
      if (o == UHLD_OP_FPX && r[8])
        x[2:0] = 3'h0;
      do_load(o, b, x, rnd(), rnd(), r[31:16], r[34:32], r[40:37] == 4'h0,
              (o == UHLD_OP_FPX) && (r[44:41] == 4'h0), (r[47:45] == 3'h0) ? r[51:48] : 4'h0,
              r[53:52]);
    end
    complete_run();
  end

  initial
  begin
    #400000;
    fails++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire

// [verification/uhld_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Memory access path seen by the datapath
module uhld_mem_model
  import uhld_pkg::*;
(
  // Clock and request
  input wire logic ref_clk,
  input wire logic req,
  // Answer prepared by the bench
  input wire logic [XLEN-1:0] data,
  input wire logic [3:0] faults,
  input wire logic [1:0] delay,
  // Answer to the datapath
  output logic mem_valid,
  output logic [XLEN-1:0] mem_dword,
  output logic [3:0] flt
);
  initial
  begin
    mem_valid = 1'b0;
    mem_dword = 64'h0;
    flt = 4'h0;
  end

  // Bus inverted after each answer so a stale word never passes for data
  always
  begin
    @(posedge ref_clk);
    if (req === 1'b1)
    begin
      repeat (delay) @(posedge ref_clk);
      #1;
      mem_valid = 1'b1;
      mem_dword = data;
      flt = faults;
      @(posedge ref_clk);
      #1;
      mem_valid = 1'b0;
      mem_dword = ~data;
      flt = 4'h0;
    end
  end
endmodule : uhld_mem_model
`default_nettype wire
